/* core/dsw_pkg.sv */
// constants and carrier types for the drive status word encoder
package dsw_pkg;

   // ----------------------------------------------------------------
   // object address and reset value
   // ----------------------------------------------------------------
   localparam logic [15:0] DSW_STATUS_INDEX = 16'h6041;
   localparam logic [15:0] DSW_STATUS_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // bit positions of the status word
   // ----------------------------------------------------------------
   localparam int DSW_BIT_READY = 0;
   localparam int DSW_BIT_SWON = 1;
   localparam int DSW_BIT_RUN = 2;
   localparam int DSW_BIT_FAULT = 3;
   localparam int DSW_BIT_POWER = 4;
   localparam int DSW_BIT_QSTOP = 5;
   localparam int DSW_BIT_NOFAULT = 6;
   localparam int DSW_BIT_WARN = 7;
   localparam int DSW_BIT_RSV8 = 8;
   localparam int DSW_BIT_REMOTE = 9;
   localparam int DSW_BIT_TGT = 10;
   localparam int DSW_BIT_LIMIT = 11;
   localparam int DSW_BIT_MS12 = 12;
   localparam int DSW_BIT_MS13 = 13;
   localparam int DSW_BIT_RSV14 = 14;
   localparam int DSW_BIT_HOME = 15;

   // ----------------------------------------------------------------
   // operating mode codes
   // ----------------------------------------------------------------
   localparam logic [7:0] DSW_MODE_NONE = 8'h00;
   localparam logic [7:0] DSW_PROFILE_POSITION_MODE = 8'h01;
   localparam logic [7:0] DSW_PROFILE_VELOCITY_MODE = 8'h03;
   localparam logic [7:0] DSW_PROFILE_TORQUE_MODE = 8'h04;
   localparam logic [7:0] DSW_HOMING_MODE = 8'h06;
   localparam logic [7:0] DSW_INTERPOLATED_POSITION_MODE = 8'h07;
   localparam logic [7:0] DSW_CYCLIC_POSITION_MODE = 8'h08;
   localparam logic [7:0] DSW_CYCLIC_VELOCITY_MODE = 8'h09;
   localparam logic [7:0] DSW_CYCLIC_TORQUE_MODE = 8'h0a;

   // ----------------------------------------------------------------
   // drive states as reported in the low nibble
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      DSW_ST_INIT = 3'b000,
      DSW_ST_NOFAULT = 3'b001,
      DSW_ST_READY = 3'b010,
      DSW_ST_SWON = 3'b011,
      DSW_ST_RUN = 3'b100,
      DSW_ST_QSTOP = 3'b101,
      DSW_ST_STOPFLT = 3'b110,
      DSW_ST_FAULT = 3'b111
   } dsw_state_t;

   localparam logic [3:0] DSW_NIB_INIT = 4'h0;
   localparam logic [3:0] DSW_NIB_READY = 4'h1;
   localparam logic [3:0] DSW_NIB_SWON = 4'h3;
   localparam logic [3:0] DSW_NIB_RUN = 4'h7;
   localparam logic [3:0] DSW_NIB_STOPFLT = 4'hf;
   localparam logic [3:0] DSW_NIB_FAULT = 4'h8;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic target_reached;
      logic halt_request;
      logic velocity_zero;
      logic setpoint_busy;
      logic following_error;
      logic follows_command;
      logic interp_active;
      logic homing_busy;
      logic homing_attained;
      logic homing_error;
   } dsw_motion_t;

   typedef struct packed {
      logic power_on;
      logic warning;
      logic remote;
      logic home_flag;
   } dsw_misc_t;

endpackage : dsw_pkg

/* core/dsw_mode_bits.sv */
// mode specific bits 10, 12 and 13 of the status word
`timescale 1ns/10ps
module dsw_mode_bits (
   input wire logic [7:0] mode,
   input wire dsw_pkg::dsw_motion_t motion,
   output logic tgt_bit,
   output logic ms12_bit,
   output logic ms13_bit
);
   import dsw_pkg::*;

   logic halt_target;

   // halt turns target reached into standstill
   always_comb begin
      if (motion.halt_request) begin
         halt_target = motion.velocity_zero;
      end else begin
         halt_target = motion.target_reached;
      end
   end

   // ----------------------------------------------------------------
   // mode selection
   // ----------------------------------------------------------------
   always_comb begin
      tgt_bit = 1'b0;
      ms12_bit = 1'b0;
      ms13_bit = 1'b0;
      case (mode)
         DSW_PROFILE_POSITION_MODE: begin
            tgt_bit = halt_target;
            ms12_bit = motion.setpoint_busy;
            ms13_bit = motion.following_error;
         end
         DSW_INTERPOLATED_POSITION_MODE: begin
            tgt_bit = halt_target;
            ms12_bit = motion.interp_active;
            ms13_bit = motion.following_error;
         end
         DSW_PROFILE_VELOCITY_MODE: begin
            tgt_bit = halt_target;
            ms12_bit = motion.velocity_zero;
            ms13_bit = 1'b0;
         end
         DSW_PROFILE_TORQUE_MODE: begin
            tgt_bit = halt_target;
            ms12_bit = 1'b0;
            ms13_bit = 1'b0;
         end
         DSW_CYCLIC_POSITION_MODE,
         DSW_CYCLIC_VELOCITY_MODE,
         DSW_CYCLIC_TORQUE_MODE: begin
            tgt_bit = 1'b0;
            ms12_bit = motion.follows_command;
            ms13_bit = motion.following_error;
         end
         DSW_HOMING_MODE: begin
            if (motion.homing_error) begin
               ms13_bit = 1'b1;
               tgt_bit = motion.velocity_zero;
            end else if (motion.homing_attained) begin
               ms12_bit = 1'b1;
               tgt_bit = motion.target_reached;
            end else begin
               tgt_bit = ~motion.homing_busy;
            end
         end
         default: begin
            tgt_bit = 1'b0;
         end
      endcase
   end

endmodule : dsw_mode_bits

/* core/dsw_status_word.sv */
// status word encoder top level
`timescale 1ns/10ps
module dsw_status_word (
   REF_CLK,
   ARST_N,
   DRIVE_STATE,
   MODE,
   MOTION,
   MISC,
   REVERSE_OVERTRAVEL_INPUT,
   FORWARD_OVERTRAVEL_INPUT,
   CYCLE_STROBE,
   STATUS_WORD,
   STATUS_INDEX
);
   import dsw_pkg::*;
   input wire logic REF_CLK;
   input wire logic ARST_N;
   input wire dsw_pkg::dsw_state_t DRIVE_STATE;
   input wire logic [7:0] MODE;
   input wire dsw_pkg::dsw_motion_t MOTION;
   input wire dsw_pkg::dsw_misc_t MISC;
   input wire logic REVERSE_OVERTRAVEL_INPUT;
   input wire logic FORWARD_OVERTRAVEL_INPUT;
   input wire logic CYCLE_STROBE;
   output logic [15:0] STATUS_WORD;
   output logic [15:0] STATUS_INDEX;

   // ----------------------------------------------------------------
   // overtravel pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] rev_sync_ff;
   logic [1:0] fwd_sync_ff;

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rev_sync_ff <= 2'h0;
         fwd_sync_ff <= 2'h0;
      end else begin
         rev_sync_ff <= {rev_sync_ff[0], REVERSE_OVERTRAVEL_INPUT};
         fwd_sync_ff <= {fwd_sync_ff[0], FORWARD_OVERTRAVEL_INPUT};
      end
   end

   // ----------------------------------------------------------------
   // state nibble
   // ----------------------------------------------------------------
   logic [3:0] nxt_nib;
   logic nxt_qstop;
   logic nxt_nofault;

   always_comb begin
      nxt_nib = DSW_NIB_INIT;
      nxt_qstop = 1'b0;
      nxt_nofault = 1'b0;
      unique case (DRIVE_STATE)
         DSW_ST_INIT: begin
            nxt_nib = DSW_NIB_INIT;
         end
         DSW_ST_NOFAULT: begin
            nxt_nib = DSW_NIB_INIT;
            nxt_nofault = 1'b1;
         end
         DSW_ST_READY: begin
            nxt_nib = DSW_NIB_READY;
            nxt_qstop = 1'b1;
         end
         DSW_ST_SWON: begin
            nxt_nib = DSW_NIB_SWON;
            nxt_qstop = 1'b1;
         end
         DSW_ST_RUN: begin
            nxt_nib = DSW_NIB_RUN;
            nxt_qstop = 1'b1;
         end
         DSW_ST_QSTOP: begin
            nxt_nib = DSW_NIB_RUN;
         end
         DSW_ST_STOPFLT: begin
            nxt_nib = DSW_NIB_STOPFLT;
         end
         DSW_ST_FAULT: begin
            nxt_nib = DSW_NIB_FAULT;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // mode specific bits
   // ----------------------------------------------------------------
   logic tgt_bit;
   logic ms12_bit;
   logic ms13_bit;

   dsw_mode_bits u_mode_bits (
      .mode(MODE),
      .motion(MOTION),
      .tgt_bit(tgt_bit),
      .ms12_bit(ms12_bit),
      .ms13_bit(ms13_bit)
   );

   // ----------------------------------------------------------------
   // word assembly
   // ----------------------------------------------------------------
   logic [15:0] nxt_word;

   always_comb begin
      nxt_word = DSW_STATUS_RESET;
      nxt_word[DSW_BIT_FAULT:DSW_BIT_READY] = nxt_nib;
      nxt_word[DSW_BIT_POWER] = MISC.power_on;
      nxt_word[DSW_BIT_QSTOP] = nxt_qstop;
      nxt_word[DSW_BIT_NOFAULT] = nxt_nofault;
      nxt_word[DSW_BIT_WARN] = MISC.warning;
      nxt_word[DSW_BIT_RSV8] = 1'b0;
      nxt_word[DSW_BIT_REMOTE] = MISC.remote;
      nxt_word[DSW_BIT_TGT] = tgt_bit;
      nxt_word[DSW_BIT_LIMIT] = rev_sync_ff[1] | fwd_sync_ff[1];
      nxt_word[DSW_BIT_MS12] = ms12_bit;
      nxt_word[DSW_BIT_MS13] = ms13_bit;
      nxt_word[DSW_BIT_RSV14] = 1'b0;
      nxt_word[DSW_BIT_HOME] = MISC.home_flag;
   end

   // ----------------------------------------------------------------
   // per-cycle capture for process data
   // ----------------------------------------------------------------
   logic [15:0] word_ff;

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         word_ff <= DSW_STATUS_RESET;
      end else if (CYCLE_STROBE) begin
         word_ff <= nxt_word;
      end
   end

   logic [15:0] index_ff;

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         index_ff <= 16'h0000;
      end else begin
         index_ff <= DSW_STATUS_INDEX;
      end
   end

   assign STATUS_WORD = word_ff;
   assign STATUS_INDEX = index_ff;

endmodule : dsw_status_word

/* bench/dsw_status_asserts.sv */
// assertion checker for the status word encoder
`timescale 1ns/10ps
module dsw_status_asserts (
   input wire logic REF_CLK,
   input wire logic ARST_N,
   input wire dsw_pkg::dsw_state_t DRIVE_STATE,
   input wire logic [7:0] MODE,
   input wire dsw_pkg::dsw_motion_t MOTION,
   input wire dsw_pkg::dsw_misc_t MISC,
   input wire logic REVERSE_OVERTRAVEL_INPUT,
   input wire logic FORWARD_OVERTRAVEL_INPUT,
   input wire logic CYCLE_STROBE,
   input wire logic [15:0] STATUS_WORD,
   input wire logic [15:0] STATUS_INDEX
);
   import dsw_pkg::*;
   logic stb;
   logic [15:0] sw;
   assign stb = CYCLE_STROBE;
   assign sw = STATUS_WORD;
   logic cyc_mode;
   assign cyc_mode = (MODE >= DSW_CYCLIC_POSITION_MODE)
      && (MODE <= DSW_CYCLIC_TORQUE_MODE);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   // ----------------------------------------------------------------
   // capture steps
   // ----------------------------------------------------------------
   sequence take(dsw_state_t st);
      stb && DRIVE_STATE == st;
   endsequence
   sequence ot_held;
      (REVERSE_OVERTRAVEL_INPUT || FORWARD_OVERTRAVEL_INPUT)[*3];
   endsequence
   AST_HOLD: assert property (!stb |=> $stable(sw))
      else $error("status word moved without strobe");
   AST_RSV: assert property (sw[8] == 1'b0 && sw[14] == 1'b0)
      else $error("reserved bit set");
   AST_RUN: assert property (take(DSW_ST_RUN)
      |=> {sw[6:5], sw[3:0]} == 6'h17)
      else $error("running code wrong");
   AST_NOFLT: assert property (take(DSW_ST_NOFAULT)
      |=> {sw[6], sw[3:0]} == 5'h10)
      else $error("no fault code wrong");
   AST_QSTOP: assert property (take(DSW_ST_QSTOP)
      |=> {sw[6:5], sw[3:0]} == 6'h07)
      else $error("quick stop code wrong");
   AST_FAULT: assert property (take(DSW_ST_FAULT)
      |=> {sw[6], sw[3:0]} == 5'h08)
      else $error("fault code wrong");
   AST_MISC: assert property (stb |=> sw[4] == $past(MISC.power_on)
      && sw[7] == $past(MISC.warning))
      else $error("power or warning bit wrong");
   AST_LIMIT: assert property (ot_held ##0 stb |=> sw[11])
      else $error("limit bit not set");
   AST_CYCLIC: assert property (stb && cyc_mode |=> !sw[10]
      && sw[12] == $past(MOTION.follows_command))
      else $error("cyclic mode bits wrong");
   AST_TORQUE: assert property (stb && MODE == DSW_PROFILE_TORQUE_MODE
      |=> sw[13:12] == 2'b00)
      else $error("torque mode bits not zero");
   AST_HOMING: assert property (stb && MODE == DSW_HOMING_MODE
      && MOTION.homing_error |=> sw[13:12] == 2'b10
      && sw[10] == $past(MOTION.velocity_zero))
      else $error("homing error bits wrong");
endmodule : dsw_status_asserts

/* bench/dsw_host_model.sv */
// host controller model latching the word into process data
`timescale 1ns/10ps
module dsw_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cycle_strobe,
   input wire logic [15:0] status_word,
   output logic [15:0] pdo_word
);
   logic seen_ff;
   logic [15:0] pdo_ff;
   assign pdo_word = pdo_ff;
   // ----------------------------------------------------------------
   // take the word once it has settled after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_ff <= 1'b0;
         pdo_ff <= 16'h0000;
      end else begin
         seen_ff <= cycle_strobe;
         if (seen_ff) begin
            pdo_ff <= status_word;
         end
      end
   end
endmodule : dsw_host_model

/* bench/testbench.sv */
// self-checking testbench for the status word encoder
`timescale 1ns/10ps
module testbench;
   import dsw_pkg::*;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   dsw_state_t drive_state = DSW_ST_INIT;
   logic [7:0] mode = 8'h00;
   dsw_motion_t motion = '0;
   dsw_misc_t misc = '0;
   logic rev_ot = 1'b0;
   logic fwd_ot = 1'b0;
   logic strobe = 1'b0;
   logic [15:0] status_word;
   logic [15:0] status_index;
   logic [15:0] pdo_word;
   int n_mismatch = 0;
   int checks_done = 0;
   logic [7:0] low_tab [8] = '{8'h00, 8'h40, 8'h21, 8'h23, 8'h27, 8'h07,
      8'h0f, 8'h08};
   dsw_status_word DUT (.REF_CLK(ref_clk), .ARST_N(arst_n),
      .DRIVE_STATE(drive_state), .MODE(mode), .MOTION(motion), .MISC(misc),
      .REVERSE_OVERTRAVEL_INPUT(rev_ot), .FORWARD_OVERTRAVEL_INPUT(fwd_ot),
      .CYCLE_STROBE(strobe), .STATUS_WORD(status_word),
      .STATUS_INDEX(status_index));
   dsw_host_model host (.clk(ref_clk), .rst_n(arst_n), .cycle_strobe(strobe),
      .status_word(status_word), .pdo_word(pdo_word));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check16
   task automatic strobe_once();
      strobe <= 1'b1;
      @(posedge ref_clk);
      strobe <= 1'b0;
      #1;
   endtask : strobe_once
   task automatic mc(input logic [7:0] m, input logic [9:0] mo,
      input logic [15:0] exp);
      @(posedge ref_clk);
      mode <= m;
      motion <= mo;
      strobe_once();
      check16(status_word, exp | 16'h0027);
   endtask : mc
   task automatic t_reset();
      @(posedge ref_clk);
      arst_n <= 1'b0;
      @(posedge ref_clk);
      #1;
      check16(status_word, DSW_STATUS_RESET);
      @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      check16(status_index, DSW_STATUS_INDEX);
      check16(status_word, DSW_STATUS_RESET);
      $display("test reset done");
   endtask : t_reset
   task automatic t_states();
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         drive_state <= dsw_state_t'(i);
         misc <= {i[0], i[1], 2'b00};
         strobe_once();
         check16(status_word, {8'h00, low_tab[i]
            | {i[1], 2'b00, i[0], 4'h0}});
      end
      $display("test states done");
   endtask : t_states
   task automatic t_limit();
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         drive_state <= DSW_ST_RUN;
         misc <= '0;
         fwd_ot <= (k == 0);
         rev_ot <= (k == 1);
         repeat (2) @(posedge ref_clk);
         strobe_once();
         check16(status_word, 16'h0827);
      end
      @(posedge ref_clk);
      fwd_ot <= 1'b0;
      rev_ot <= 1'b0;
      repeat (2) @(posedge ref_clk);
      strobe_once();
      check16(status_word, 16'h0027);
      $display("test limit done");
   endtask : t_limit
   task automatic t_modes();
      mc(8'h01, 10'h200, 16'h0400);
      mc(8'h01, 10'h300, 16'h0000);
      mc(8'h01, 10'h180, 16'h0400);
      mc(8'h01, 10'h040, 16'h1000);
      mc(8'h01, 10'h000, 16'h0000);
      mc(8'h01, 10'h020, 16'h2000);
      mc(8'h06, 10'h004, 16'h0000);
      mc(8'h06, 10'h000, 16'h0400);
      mc(8'h06, 10'h002, 16'h1000);
      mc(8'h06, 10'h202, 16'h1400);
      mc(8'h06, 10'h001, 16'h2000);
      mc(8'h06, 10'h081, 16'h2400);
      mc(8'h08, 10'h210, 16'h1000);
      mc(8'h09, 10'h020, 16'h2000);
      mc(8'h0a, 10'h010, 16'h1000);
      mc(8'h07, 10'h008, 16'h1000);
      mc(8'h07, 10'h120, 16'h2000);
      mc(8'h03, 10'h0a0, 16'h1000);
      mc(8'h04, 10'h27f, 16'h0400);
      mc(8'h02, 10'h3ff, 16'h0000);
      $display("test modes done");
   endtask : t_modes
   task automatic t_hold();
      @(posedge ref_clk);
      mode <= 8'h00;
      drive_state <= DSW_ST_READY;
      misc <= 4'b0011;
      strobe_once();
      @(posedge ref_clk);
      drive_state <= DSW_ST_FAULT;
      repeat (3) @(posedge ref_clk);
      #1;
      check16(status_word, 16'h8221);
      check16(pdo_word, 16'h8221);
      @(posedge ref_clk);
      strobe <= 1'b1;
      drive_state <= DSW_ST_SWON;
      @(posedge ref_clk);
      drive_state <= DSW_ST_RUN;
      #1;
      check16(status_word, 16'h8223);
      @(posedge ref_clk);
      strobe <= 1'b0;
      #1;
      check16(status_word, 16'h8227);
      $display("test hold done");
   endtask : t_hold
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (10) @(posedge ref_clk);
      t_reset();
      t_states();
      t_limit();
      t_modes();
      t_hold();
      t_reset();
      summarize();
   end
endmodule : testbench
bind dsw_status_word dsw_status_asserts u_chk (.REF_CLK(REF_CLK),
   .ARST_N(ARST_N), .DRIVE_STATE(DRIVE_STATE), .MODE(MODE), .MOTION(MOTION),
   .MISC(MISC), .REVERSE_OVERTRAVEL_INPUT(REVERSE_OVERTRAVEL_INPUT),
   .FORWARD_OVERTRAVEL_INPUT(FORWARD_OVERTRAVEL_INPUT),
   .CYCLE_STROBE(CYCLE_STROBE), .STATUS_WORD(STATUS_WORD),
   .STATUS_INDEX(STATUS_INDEX));
